/* File: hdl/mrr_pkg.sv */
// constants and types for the move/return/rotate execution block
package mrr_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 11;
    localparam logic [PC_W-1:0] PC_STEP = 11'h001;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 11'h000;
    localparam int MSB = 7;
    localparam int LSB = 0;
    // operation select given by the surrounding decoder
    typedef enum logic [2:0] {
        MRR_IDLE = 3'b000,
        MRR_LOAD_LIT = 3'b001,
        MRR_MOVE_REG = 3'b010,
        MRR_RET_IRQ = 3'b011,
        MRR_RET_LIT = 3'b100,
        MRR_RET_SUB = 3'b101,
        MRR_ROT_LEFT = 3'b110,
        MRR_ROT_RIGHT = 3'b111
    } mrr_op_e;
    // execution phase: returns use a second cycle
    typedef enum logic [0:0] {
        MRR_EXEC = 1'b0,
        MRR_SECOND = 1'b1
    } mrr_state_e;
endpackage

/* File: hdl/mrr_exec.sv */
// execution unit for load literal, idle, move, returns and rotates
//
// Overview of operation
// - load literal copies 8-bit literal into work register, one cycle, flags unchanged.
// - idle op changes nothing but advances program counter by one, one cycle.
// - move reads register 0..127, writes work register if d=0, source if d=1.
// - move sets zero flag from moved value, also when written back.
// - return-irq loads pc from stack top, pops, sets global irq enable, two cycles.
// - return-literal loads literal to work register, pc from stack, pops, two cycles.
// - return-subroutine loads pc from stack top, pops one level, two cycles.
// - rotate left: bits 6..0 to 7..1, old carry to bit 0, bit 7 to carry.
// - rotate left result to work or source register per d, one cycle, carry only.
// - rotate right: bits 7..1 to 6..0, carry to bit 7, bit 0 to carry.
`timescale 1ns/1ps
`default_nettype none
module mrr_exec (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic op_valid_i,
    input wire mrr_pkg::mrr_op_e op_i,
    input wire logic [mrr_pkg::DATA_W-1:0] literal_i,
    input wire logic [mrr_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic dest_sel_i,
    input wire logic [mrr_pkg::DATA_W-1:0] reg_rdata_i,
    input wire logic [mrr_pkg::PC_W-1:0] stack_top_i,
    output logic busy_o,
    output logic [mrr_pkg::DATA_W-1:0] work_register_o,
    output logic [mrr_pkg::PC_W-1:0] pc_o,
    output logic zero_flag_o,
    output logic digit_carry_o,
    output logic carry_flag_o,
    output logic global_irq_enable_o,
    output logic stack_pop_o,
    output logic reg_we_o,
    output logic [mrr_pkg::ADDR_W-1:0] reg_waddr_o,
    output logic [mrr_pkg::DATA_W-1:0] reg_wdata_o
);
    import mrr_pkg::*;

    mrr_state_e state_q, state_d;
    logic [DATA_W-1:0] work_q, work_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic zero_q, zero_d;
    logic dc_q;
    logic carry_q, carry_d;
    logic irq_en_q, irq_en_d;
    logic busy_q;
    logic pop_q, pop_d;
    logic we_q, we_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;

    // decode helpers
    // an offer during the second return cycle is dropped, never queued
    wire logic take = op_valid_i && (state_q == MRR_EXEC);
    wire logic is_ret = (op_i == MRR_RET_IRQ) || (op_i == MRR_RET_LIT) || (op_i == MRR_RET_SUB);
    wire logic is_rot = (op_i == MRR_ROT_LEFT) || (op_i == MRR_ROT_RIGHT);
    wire logic is_move = op_i == MRR_MOVE_REG;
    // register data arrives combinationally from the file read port in the same cycle
    // rotate results through carry
    wire logic [DATA_W-1:0] rot_left = {reg_rdata_i[MSB-1:LSB], carry_q};
    wire logic [DATA_W-1:0] rot_right = {carry_q, reg_rdata_i[MSB:LSB+1]};
    wire logic [DATA_W-1:0] rot_res = (op_i == MRR_ROT_LEFT) ? rot_left : rot_right;
    wire logic rot_carry = (op_i == MRR_ROT_LEFT) ? reg_rdata_i[MSB] : reg_rdata_i[LSB];
    // value headed for a data destination
    wire logic [DATA_W-1:0] res = is_rot ? rot_res : reg_rdata_i;
    wire logic to_source = take && (is_move || is_rot) && dest_sel_i;

    // next-state: returns spend a second cycle, everything else finishes at once
    always_comb begin
        state_d = state_q;
        work_d = work_q;
        pc_d = pc_q;
        zero_d = zero_q;
        carry_d = carry_q;
        irq_en_d = irq_en_q;
        pop_d = 1'b0;
        we_d = to_source;
        waddr_d = reg_addr_i;
        wdata_d = res;
        unique case (state_q)
            MRR_EXEC: begin
                if (take) begin
                    // returns take pc from the stack top with no increment; the stack lives outside
                    if (is_ret) begin
                        state_d = MRR_SECOND;
                        pc_d = stack_top_i;
                        pop_d = 1'b1;
                        if (op_i == MRR_RET_IRQ) begin
                            irq_en_d = 1'b1;
                        end
                        if (op_i == MRR_RET_LIT) begin
                            work_d = literal_i;
                        end
                    end else begin
                        pc_d = pc_q + PC_STEP;
                    end
                    if (op_i == MRR_LOAD_LIT) begin
                        work_d = literal_i;
                    end
                    if ((is_move || is_rot) && !dest_sel_i) begin
                        work_d = res;
                    end
                    if (is_move) begin
                        zero_d = (reg_rdata_i == ZERO_BYTE);
                    end
                    if (is_rot) begin
                        carry_d = rot_carry;
                    end
                end
            end
            MRR_SECOND: begin
                state_d = MRR_EXEC; // second return cycle is a bubble
            end
        endcase
    end

    // state registers; digit carry is never touched by this subset
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_q <= MRR_EXEC;
            work_q <= ZERO_BYTE;
            pc_q <= PC_RESET;
            zero_q <= 1'b0;
            dc_q <= 1'b0;
            carry_q <= 1'b0;
            irq_en_q <= 1'b0;
            busy_q <= 1'b0;
            pop_q <= 1'b0;
            we_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= ZERO_BYTE;
        end else begin
            state_q <= state_d;
            work_q <= work_d;
            pc_q <= pc_d;
            zero_q <= zero_d;
            carry_q <= carry_d;
            irq_en_q <= irq_en_d;
            // busy taken from the next state so the port is a plain flop
            busy_q <= (state_d == MRR_SECOND);
            pop_q <= pop_d;
            we_q <= we_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
        end
    end

    // outputs straight from flops
    assign busy_o = busy_q;
    assign work_register_o = work_q;
    assign pc_o = pc_q;
    assign zero_flag_o = zero_q;
    assign digit_carry_o = dc_q;
    assign carry_flag_o = carry_q;
    assign global_irq_enable_o = irq_en_q;
    assign stack_pop_o = pop_q;
    assign reg_we_o = we_q;
    assign reg_waddr_o = waddr_q;
    assign reg_wdata_o = wdata_q;

    // checks
    sequence s_ret_taken;
        take && is_ret;
    endsequence
    sequence s_ret_done;
        stack_pop_o && busy_o ##1 !busy_o;
    endsequence

    a_load_literal: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && op_i == MRR_LOAD_LIT |=> work_q == $past(literal_i) && carry_q == $past(carry_q)
        && zero_q == $past(zero_q)) else $error("literal load wrong");
    a_idle_pc: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && op_i == MRR_IDLE |=> pc_q == $past(pc_q) + PC_STEP && work_q == $past(work_q)
        && !we_q) else $error("idle op changed state");
    a_move_dest: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && is_move && dest_sel_i |=> we_q && wdata_q == $past(reg_rdata_i)
        && waddr_q == $past(reg_addr_i) && work_q == $past(work_q)) else $error("move writeback wrong");
    a_move_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && is_move |=> zero_q == ($past(reg_rdata_i) == ZERO_BYTE)) else $error("move zero flag wrong");
    a_ret_irq: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && op_i == MRR_RET_IRQ |=> irq_en_q && pc_q == $past(stack_top_i)) else $error("irq return wrong");
    a_ret_literal: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && op_i == MRR_RET_LIT |=> work_q == $past(literal_i)) else $error("literal return wrong");
    a_ret_two_cycles: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_ret_taken |=> s_ret_done) else $error("return not two cycles");
    a_rot_left: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && op_i == MRR_ROT_LEFT |=> carry_q == $past(reg_rdata_i[MSB])
        && wdata_q == {$past(reg_rdata_i[MSB-1:LSB]), $past(carry_q)}) else $error("rotate left wrong");
    a_rot_left_flags: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && op_i == MRR_ROT_LEFT && !dest_sel_i |=> !we_q && work_q == wdata_q
        && zero_q == $past(zero_q)) else $error("rotate left dest wrong");
    a_rot_right: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && op_i == MRR_ROT_RIGHT |=> carry_q == $past(reg_rdata_i[LSB])
        && wdata_q == {$past(carry_q), $past(reg_rdata_i[MSB:LSB+1])}) else $error("rotate right wrong");
    a_flags_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && !is_move && !is_rot |=> zero_q == $past(zero_q) && carry_q == $past(carry_q)
        && $stable(dc_q)) else $error("flag disturbed");

    // destinations, pulse widths and offers refused during the bubble
    a_move_work: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && is_move && !dest_sel_i |=> !we_q && work_q == $past(reg_rdata_i))
        else $error("move to work register wrong");
    a_ret_sub_pc: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && op_i == MRR_RET_SUB |=> pc_q == $past(stack_top_i) && work_q == $past(work_q) && !we_q
        && stack_pop_o) else $error("subroutine return wrong");
    a_busy_refused: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        busy_o && op_valid_i |=> work_q == $past(work_q) && pc_q == $past(pc_q) && !we_q && !stack_pop_o
        && !busy_o && zero_q == $past(zero_q) && carry_q == $past(carry_q)) else $error("offer taken while busy");
    a_rot_right_dest: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && op_i == MRR_ROT_RIGHT |=> we_q == $past(dest_sel_i) && work_q == (we_q ? $past(work_q) : wdata_q)
        && zero_q == $past(zero_q)) else $error("rotate right dest wrong");
    a_pop_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        stack_pop_o |=> !stack_pop_o) else $error("stack pop longer than one cycle");
    a_ret_lit_pc: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && op_i == MRR_RET_LIT |=> pc_q == $past(stack_top_i) && stack_pop_o && zero_q == $past(zero_q)
        && carry_q == $past(carry_q)) else $error("literal return pc wrong");
    a_load_one_cycle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        take && op_i == MRR_LOAD_LIT |=> !busy_o && !stack_pop_o && !we_q && pc_q == $past(pc_q) + PC_STEP)
        else $error("literal load not single cycle");
endmodule
`default_nettype wire

/* File: verification/mrr_exec_tb_top.sv */
// self-checking bench for the move/return/rotate execution block
`timescale 1ns/1ps
`default_nettype none
module mrr_exec_tb_top;
    import mrr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic vld = 1'b0;
    logic [2:0] op_b = 3'h0;
    logic [7:0] lit = 8'h00;
    logic [6:0] addr = 7'h00;
    logic dsel = 1'b0;
    logic [7:0] rd = 8'h00;
    logic [10:0] top = 11'h000;
    logic busy, z, dc, c, irq_en, pop, we;
    logic [7:0] work, wdata;
    logic [10:0] pc;
    logic [6:0] waddr;
    int fails = 0;
    int check_count = 0;
    // 50 MHz core clock
    always #10 clk = ~clk;
    mrr_exec dut_u (.ref_clk_i(clk), .rst_n_i(rst_n), .op_valid_i(vld), .op_i(mrr_op_e'(op_b)),
        .literal_i(lit), .reg_addr_i(addr), .dest_sel_i(dsel), .reg_rdata_i(rd), .stack_top_i(top),
        .busy_o(busy), .work_register_o(work), .pc_o(pc), .zero_flag_o(z), .digit_carry_o(dc),
        .carry_flag_o(c), .global_irq_enable_o(irq_en), .stack_pop_o(pop), .reg_we_o(we),
        .reg_waddr_o(waddr), .reg_wdata_o(wdata));
    // compare tasks: case equality so an unknown never matches
    task automatic chk_val(input string n, input logic [10:0] e, input logic [10:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        chk_val(n, {10'h000, e}, {10'h000, g});
    endtask
    // one instruction for one taking edge; keep offers a refused load during the bubble
    task automatic issue(input logic [2:0] o, input logic [7:0] l, input logic [6:0] a, input logic d,
                         input logic [7:0] r, input logic [10:0] t, input logic keep);
        @(negedge clk);
        {op_b, lit, addr, dsel, rd, top} = {o, l, a, d, r, t};
        vld = 1'b1;
        @(negedge clk);
        vld = keep;
        if (keep) begin
            op_b = MRR_LOAD_LIT;
            lit = 8'hEE;
        end
    endtask
    task automatic st(input logic [7:0] w, input logic [10:0] p, input logic zf, input logic cf);
        chk_val("work_register", 11'(w), 11'(work));
        chk_val("pc", p, pc);
        chk_bit("zero_flag", zf, z);
        chk_bit("carry_flag", cf, c);
        chk_bit("digit_carry", 1'b0, dc);
    endtask
    task automatic wr(input logic e, input logic [6:0] a, input logic [7:0] dd);
        chk_bit("reg_we", e, we);
        chk_val("reg_waddr", 11'(a), 11'(waddr));
        chk_val("reg_wdata", 11'(dd), 11'(wdata));
    endtask
    task automatic rt(input logic p, input logic b, input logic g);
        chk_bit("stack_pop", p, pop);
        chk_bit("busy", b, busy);
        chk_bit("irq_enable", g, irq_en);
    endtask
    task automatic wrap_up;
        if (fails == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // main sequence; expectations follow from the previous carry and zero state
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        st(8'h00, 11'h000, 1'b0, 1'b0);
        rt(1'b0, 1'b0, 1'b0);
        issue(MRR_LOAD_LIT, 8'h55, 7'h00, 1'b0, 8'hFF, 11'h000, 1'b0);
        st(8'h55, 11'h001, 1'b0, 1'b0);
        issue(MRR_IDLE, 8'h99, 7'h05, 1'b1, 8'h12, 11'h000, 1'b0);
        st(8'h55, 11'h002, 1'b0, 1'b0);
        chk_bit("reg_we", 1'b0, we);
        issue(MRR_MOVE_REG, 8'h00, 7'h7F, 1'b0, 8'h00, 11'h000, 1'b0);
        st(8'h00, 11'h003, 1'b1, 1'b0);
        chk_bit("reg_we", 1'b0, we);
        issue(MRR_MOVE_REG, 8'h00, 7'h00, 1'b1, 8'h3C, 11'h000, 1'b0);
        st(8'h00, 11'h004, 1'b0, 1'b0);
        wr(1'b1, 7'h00, 8'h3C);
        issue(MRR_ROT_LEFT, 8'h00, 7'h11, 1'b1, 8'hA5, 11'h000, 1'b0);
        st(8'h00, 11'h005, 1'b0, 1'b1);
        wr(1'b1, 7'h11, 8'h4A);
        issue(MRR_ROT_LEFT, 8'h00, 7'h12, 1'b0, 8'h01, 11'h000, 1'b0);
        st(8'h03, 11'h006, 1'b0, 1'b0);
        chk_bit("reg_we", 1'b0, we);
        issue(MRR_ROT_RIGHT, 8'h00, 7'h22, 1'b1, 8'hA5, 11'h000, 1'b0);
        st(8'h03, 11'h007, 1'b0, 1'b1);
        wr(1'b1, 7'h22, 8'h52);
        issue(MRR_ROT_RIGHT, 8'h00, 7'h23, 1'b0, 8'h00, 11'h000, 1'b0);
        st(8'h80, 11'h008, 1'b0, 1'b0);
        issue(MRR_MOVE_REG, 8'h00, 7'h33, 1'b1, 8'h00, 11'h000, 1'b0);
        st(8'h80, 11'h009, 1'b1, 1'b0);
        wr(1'b1, 7'h33, 8'h00);
        issue(MRR_ROT_LEFT, 8'h00, 7'h34, 1'b0, 8'h80, 11'h000, 1'b0);
        st(8'h00, 11'h00A, 1'b1, 1'b1);
        issue(MRR_RET_IRQ, 8'h00, 7'h00, 1'b0, 8'h00, 11'h7FF, 1'b1);
        st(8'h00, 11'h7FF, 1'b1, 1'b1);
        rt(1'b1, 1'b1, 1'b1);
        @(negedge clk);
        vld = 1'b0;
        st(8'h00, 11'h7FF, 1'b1, 1'b1);
        rt(1'b0, 1'b0, 1'b1);
        issue(MRR_RET_LIT, 8'hAA, 7'h00, 1'b0, 8'h00, 11'h123, 1'b0);
        st(8'hAA, 11'h123, 1'b1, 1'b1);
        rt(1'b1, 1'b1, 1'b1);
        issue(MRR_RET_SUB, 8'h5A, 7'h00, 1'b0, 8'h00, 11'h456, 1'b0);
        st(8'hAA, 11'h456, 1'b1, 1'b1);
        rt(1'b1, 1'b1, 1'b1);
        issue(MRR_LOAD_LIT, 8'hC3, 7'h00, 1'b0, 8'h00, 11'h000, 1'b0);
        st(8'hC3, 11'h457, 1'b1, 1'b1);
        rt(1'b0, 1'b0, 1'b1);
        wrap_up;
    end
endmodule
`default_nettype wire
